// ===== verilog/scm_regs.svh
// register offsets, field positions, reset values and timing counts for the clock/mode block
// assumes a 100 MHz bus clock; oscillators are modelled by ready inputs from analog cells
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH
`define SCM_SYSCLK_OFS      8'h00
`define SCM_FASTOSC_OFS     8'h04
`define SCM_STATUS_OFS      8'h08
`define SCM_HALT_OFS        8'h0C
`define SCM_SYSCLK_RST      8'h00
`define SCM_FASTOSC_RST     8'h01
`define SCM_SEL_HI          7
`define SCM_SEL_LO          5
`define SCM_FHS_BIT         3
`define SCM_FSS_BIT         2
`define SCM_HIDLE_BIT       1
`define SCM_LIDLE_BIT       0
`define SCM_FREQ_HI         3
`define SCM_FREQ_LO         2
`define SCM_STABLE_BIT      1
`define SCM_EN_BIT          0
`define SCM_SEL_SLOW        3'h7
`define SCM_SWITCH_BASE     4
`define SCM_SYNC_MARGIN     2
`endif

// ===== verilog/scm_pkg.sv
// types for the system clock and power-mode control block
// shared by the design and its bench
package scm_pkg;
   typedef enum logic [2:0] {
      SCM_RUN    = 3'b000,
      SCM_IDLE_MODE_ZERO  = 3'b001,
      SCM_IDLE_MODE_ONE  = 3'b011,
      SCM_IDLE_MODE_TWO  = 3'b010,
      SCM_SLEEP  = 3'b110
   } scm_mode_t;

   typedef enum logic [1:0] {
      SCM_SW_IDLE = 2'b00,
      SCM_SW_WAIT = 2'b01,
      SCM_SW_GAP  = 2'b11
   } scm_sw_t;

   typedef struct packed {
      logic fast_osc_on;
      logic slow_osc_on;
      logic fast_clk_on;
      logic slow_clk_on;
      logic sys_clk_on;
   } scm_clk_en_t;

   typedef struct packed {
      logic power_down_set;
      logic timeout_clr;
      logic wdt_clr;
      logic hold_state;
   } scm_pd_t;
endpackage

// ===== verilog/scm_ctrl.sv
// system clock selection and halt/idle/sleep mode control with a wishbone slave
// assumes osc ready inputs come from analog cells in other domains; halt and wake
// are one-cycle pulses from the cpu core on clk_i
`timescale 1ns/1ns
`include "scm_regs.svh"

// What this block does
// - select code 0..6 divides fast clock by 1..64, code 7 picks slow clock
// - high-speed idle enable keeps fast oscillator running after halt
// - low-speed idle enable keeps slow oscillator running after halt
// - clock switch waits for the target oscillator stable, then four cycles plus resync margin
// - frequency field: 00 8MHz, 01 12MHz, 10 16MHz, 11 8MHz
// - new fast frequency applied only after stable flag rises
// - enabling fast oscillator clears stable flag, then sets it when stable
// - fast oscillator enable: 0 off unless a fast clock select is requested, 1 on, resets to 1
// - halt with both idle enables 0 enters sleep, all clocks stop
// - halt with high 0, low 1 enters idle zero, slow clock runs
// - halt with both idle enables 1 enters idle one, both clocks run
// - halt with high 1, low 0 enters idle two, fast clock only
// - power-down entry sets power-down flag and clears timeout flag
// - power-down entry clears watchdog counter
// - state held unchanged during sleep and idle
// - switch to slow clock waits for slow oscillator stable
// - return to fast clock waits for fast oscillator restart
// - unimplemented bits read as zero
module scm_ctrl
   import scm_pkg::*;
(
   input  wire logic        clk_i,            // 100 MHz bus clock
   input  wire logic        rst_i,            // synchronous reset, active high
   input  wire logic        wb_cyc_i,         // wishbone cycle
   input  wire logic        wb_stb_i,         // wishbone strobe
   input  wire logic        wb_we_i,          // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,         // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,         // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,         // wishbone write data
   output logic      [31:0] wb_dat_o,         // wishbone read data
   output logic             wb_ack_o,         // wishbone acknowledge
   output logic             wb_err_o,         // wishbone error, unmapped address
   input  wire logic        halt_i,           // halt instruction pulse
   input  wire logic        wake_i,           // wake-up pulse
   input  wire logic        fast_osc_rdy_i,   // fast oscillator stable, async
   input  wire logic        slow_osc_rdy_i,   // slow oscillator stable, async
   output logic             fast_osc_en_o,    // fast oscillator run request
   output logic [1:0]       fast_osc_freq_o,  // applied fast frequency code
   output logic             slow_osc_en_o,    // slow oscillator run request
   output logic [2:0]       sys_clk_sel_o,    // applied system clock select
   output logic             sys_clk_en_o,     // system clock gate
   output logic             fast_clk_en_o,    // fast peripheral clock gate
   output logic             slow_clk_en_o,    // slow peripheral clock gate
   output logic             cpu_hold_o,       // freeze cpu, memory and ports
   output logic             power_down_flag_o,     // power-down status flag
   output logic             watchdog_timeout_clr_o,// clear timeout flag pulse
   output logic             watchdog_clr_o,   // clear watchdog counter pulse
   output logic [2:0]       mode_o            // current operating mode
);
   logic [7:0]  sysclk_ff;
   logic [1:0]  freq_req_ff;
   logic        fast_en_ff;
   logic        stable_ff;
   logic        fast_sync1_ff, fast_sync2_ff;
   logic        slow_sync1_ff, slow_sync2_ff;
   scm_mode_t   mode_ff, nxt_mode;
   scm_sw_t     sw_ff;
   logic [2:0]  sel_ff;
   logic [3:0]  sw_cnt_ff;
   logic [1:0]  freq_ff;
   logic        pd_flag_ff;
   logic        to_clr_ff;
   logic        wdt_clr_ff;
   logic        ack_ff, err_ff;
   logic [31:0] rdat_ff;
   scm_clk_en_t clk_en;
   logic        wr, rd_hit, hit;
   logic        fast_stable;
   logic        tgt_ready;
   logic        halt_take;

   // bus decode: one-cycle answer, ack dropped the cycle after
   assign hit = (wb_adr_i == `SCM_SYSCLK_OFS) || (wb_adr_i == `SCM_FASTOSC_OFS)
              || (wb_adr_i == `SCM_STATUS_OFS) || (wb_adr_i == `SCM_HALT_OFS);
   // writes land at the edge where the master samples ack, never earlier
   assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && hit
                   && ack_ff;
   assign rd_hit = wb_cyc_i && wb_stb_i && !ack_ff && !err_ff;

   // oscillator ready lines cross from analog domains through two flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_sync1_ff <= 1'b0;
         fast_sync2_ff <= 1'b0;
      end else begin
         fast_sync1_ff <= fast_osc_rdy_i;
         fast_sync2_ff <= fast_sync1_ff;
      end
   end

   // only the second flop is read, so a metastable first stage never leaks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slow_sync1_ff <= 1'b0;
         slow_sync2_ff <= 1'b0;
      end else begin
         slow_sync1_ff <= slow_osc_rdy_i;
         slow_sync2_ff <= slow_sync1_ff;
      end
   end

   // system clock control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysclk_ff <= `SCM_SYSCLK_RST;
      end else if (wr && wb_adr_i == `SCM_SYSCLK_OFS) begin
         sysclk_ff <= wb_dat_i[7:0] & 8'hEF;
      end
   end

   // fast oscillator control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_en_ff  <= 1'(`SCM_FASTOSC_RST);
         freq_req_ff <= 2'h0;
      end else if (wr && wb_adr_i == `SCM_FASTOSC_OFS) begin
         fast_en_ff  <= wb_dat_i[`SCM_EN_BIT];
         freq_req_ff <= wb_dat_i[`SCM_FREQ_HI:`SCM_FREQ_LO];
      end
   end

   assign fast_stable = fast_sync2_ff && clk_en.fast_osc_on;

   // stable flag and applied frequency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stable_ff <= 1'b0;
         freq_ff   <= 2'h0;
      end else if (wr && wb_adr_i == `SCM_FASTOSC_OFS
                   && ((wb_dat_i[`SCM_EN_BIT] && !fast_en_ff)
                       || wb_dat_i[`SCM_FREQ_HI:`SCM_FREQ_LO] != freq_req_ff)) begin
         // flag cleared on enable or retune
         stable_ff <= 1'b0;
      end else if (!clk_en.fast_osc_on) begin
         stable_ff <= 1'b0;
      end else if (!stable_ff && fast_stable) begin
         stable_ff <= 1'b1;
         // frequency applied after flag rises; 11 behaves as 00 in the cell
         freq_ff   <= freq_req_ff;
      end
   end

   // halt and wake mode machine
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         SCM_RUN: begin
            if (halt_i) begin
               case ({sysclk_ff[`SCM_HIDLE_BIT], sysclk_ff[`SCM_LIDLE_BIT]})
                  2'b00:   nxt_mode = SCM_SLEEP;
                  2'b01:   nxt_mode = SCM_IDLE_MODE_ZERO;
                  2'b11:   nxt_mode = SCM_IDLE_MODE_ONE;
                  default: nxt_mode = SCM_IDLE_MODE_TWO;
               endcase
            end
         end
         SCM_IDLE_MODE_ZERO, SCM_IDLE_MODE_ONE, SCM_IDLE_MODE_TWO, SCM_SLEEP: begin
            if (wake_i) begin
               nxt_mode = SCM_RUN;
            end
         end
         default: nxt_mode = SCM_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= SCM_RUN;
      end else begin
         mode_ff <= nxt_mode;
      end
   end

   // a halt only counts in run; a repeat while stopped is ignored
   assign halt_take = (mode_ff == SCM_RUN) && halt_i;

   // power-down status: set wins over a software clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pd_flag_ff <= 1'b0;
      end else if (halt_take) begin
         pd_flag_ff <= 1'b1;
      end else if (wr && wb_adr_i == `SCM_STATUS_OFS && wb_dat_i[0]) begin
         pd_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         to_clr_ff <= 1'b0;
      end else begin
         to_clr_ff <= halt_take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_clr_ff <= 1'b0;
      end else begin
         wdt_clr_ff <= halt_take;
      end
   end

   // oscillator and clock gates per mode
   always_comb begin
      clk_en = '0;
      case (mode_ff)
         SCM_RUN: begin
            // fast oscillator follows its enable, forced on while a fast select is requested
            clk_en.fast_osc_on = fast_en_ff || (sysclk_ff[7:5] != `SCM_SEL_SLOW);
            clk_en.slow_osc_on = 1'b1;
            clk_en.fast_clk_on = clk_en.fast_osc_on;
            clk_en.slow_clk_on = 1'b1;
            clk_en.sys_clk_on  = 1'b1;
         end
         SCM_IDLE_MODE_ZERO: begin
            clk_en.slow_osc_on = 1'b1;
            clk_en.slow_clk_on = 1'b1;
            clk_en.sys_clk_on  = (sel_ff == `SCM_SEL_SLOW);
         end
         SCM_IDLE_MODE_ONE: begin
            clk_en = '1;
         end
         SCM_IDLE_MODE_TWO: begin
            clk_en.fast_osc_on = 1'b1;
            clk_en.fast_clk_on = 1'b1;
            clk_en.sys_clk_on  = (sel_ff != `SCM_SEL_SLOW);
         end
         default: clk_en = '0;
      endcase
   end

   assign tgt_ready = (sysclk_ff[7:5] == `SCM_SEL_SLOW) ? slow_sync2_ff : stable_ff;

   // glitch-free switch sequencer: wait, change select and gate off at the same edge, gate on after margin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_ff     <= SCM_SW_IDLE;
         sel_ff    <= 3'(`SCM_SYSCLK_RST >> `SCM_SEL_LO);
         sw_cnt_ff <= 4'h0;
      end else if (mode_ff == SCM_RUN) begin
         case (sw_ff)
            SCM_SW_IDLE: begin
               if (sysclk_ff[7:5] != sel_ff) begin
                  sw_ff     <= SCM_SW_WAIT;
                  sw_cnt_ff <= 4'h0;
               end
            end
            SCM_SW_WAIT: begin
               // target oscillator must be stable first
               if (tgt_ready) begin
                  if (sw_cnt_ff == 4'(`SCM_SWITCH_BASE - 1)) begin
                     sw_ff     <= SCM_SW_GAP;
                     sw_cnt_ff <= 4'h0;
                     // code 0..6 picks a fast divide, 7 the slow source
                     sel_ff    <= sysclk_ff[7:5];
                  end else begin
                     sw_cnt_ff <= sw_cnt_ff + 4'h1;
                  end
               end
            end
            SCM_SW_GAP: begin
               // output gated for a margin starting at the select change
               if (sw_cnt_ff == 4'(`SCM_SYNC_MARGIN - 1)) begin
                  sw_ff <= SCM_SW_IDLE;
               end else begin
                  sw_cnt_ff <= sw_cnt_ff + 4'h1;
               end
            end
            default: sw_ff <= SCM_SW_IDLE;
         endcase
      end
   end

   // oscillator requests and applied frequency
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_osc_en_o   <= 1'b1;
         fast_osc_freq_o <= 2'h0;
         slow_osc_en_o   <= 1'b1;
      end else begin
         fast_osc_en_o   <= clk_en.fast_osc_on;
         fast_osc_freq_o <= freq_ff;
         slow_osc_en_o   <= clk_en.slow_osc_on;
      end
   end

   // clock select and gates
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_clk_sel_o   <= 3'h0;
         sys_clk_en_o    <= 1'b1;
         fast_clk_en_o   <= 1'b1;
         slow_clk_en_o   <= 1'b1;
      end else begin
         // select code handed to the divider and source mux
         sys_clk_sel_o   <= sel_ff;
         sys_clk_en_o    <= clk_en.sys_clk_on && (sw_ff != SCM_SW_GAP);
         fast_clk_en_o   <= clk_en.fast_clk_on;
         slow_clk_en_o   <= clk_en.slow_clk_on;
      end
   end

   // mode and power-down status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_hold_o             <= 1'b0;
         mode_o                 <= SCM_RUN;
         power_down_flag_o      <= 1'b0;
         watchdog_timeout_clr_o <= 1'b0;
         watchdog_clr_o         <= 1'b0;
      end else begin
         cpu_hold_o             <= (mode_ff != SCM_RUN);
         mode_o                 <= mode_ff;
         power_down_flag_o      <= pd_flag_ff;
         watchdog_timeout_clr_o <= to_clr_ff;
         watchdog_clr_o         <= wdt_clr_ff;
      end
   end

   // bus answer: ack or err for one cycle, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         err_ff <= 1'b0;
      end else begin
         ack_ff <= rd_hit && hit;
         err_ff <= rd_hit && !hit;
      end
   end

   // read data registered with the answer; writes refresh it too, harmlessly
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdat_ff <= 32'h0000_0000;
      end else begin
         case (wb_adr_i)
            `SCM_SYSCLK_OFS:  rdat_ff <= {24'h00_0000, sysclk_ff};
            `SCM_FASTOSC_OFS: rdat_ff <= {28'h000_0000, freq_req_ff, stable_ff, fast_en_ff};
            `SCM_STATUS_OFS:  rdat_ff <= {24'h00_0000, sw_ff != SCM_SW_IDLE, sel_ff,
                                          1'b0, mode_ff};
            default:          rdat_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign wb_dat_o = rdat_ff;
   assign wb_ack_o = ack_ff;
   assign wb_err_o = err_ff;
endmodule

// ===== test/scm_ctrl_sva.sv
// port checker for the clock and power-mode control block
// assumes one clock domain; bound to every scm_ctrl instance
`timescale 1ns/1ns
module scm_ctrl_sva
   import scm_pkg::*;
(
   input wire logic        clk_i,                  // bus clock
   input wire logic        rst_i,                  // sync reset
   input wire logic        wb_cyc_i,               // bus cycle
   input wire logic        wb_stb_i,               // bus strobe
   input wire logic [31:0] wb_dat_o,               // read data
   input wire logic        wb_ack_o,               // acknowledge
   input wire logic        wb_err_o,               // error
   input wire logic        halt_i,                 // halt pulse
   input wire logic        fast_osc_rdy_i,         // fast osc ready
   input wire logic [1:0]  fast_osc_freq_o,        // applied frequency
   input wire logic [2:0]  sys_clk_sel_o,          // applied select
   input wire logic        sys_clk_en_o,           // system gate
   input wire logic        fast_clk_en_o,          // fast gate
   input wire logic        slow_clk_en_o,          // slow gate
   input wire logic        cpu_hold_o,             // cpu freeze
   input wire logic        power_down_flag_o,      // power-down flag
   input wire logic        watchdog_timeout_clr_o, // timeout clear
   input wire logic        watchdog_clr_o,         // counter clear
   input wire logic [2:0]  mode_o                  // mode
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
      else $error("bus answer missing");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   halt_flags_a: assert property (halt_i && mode_o == SCM_RUN |-> ##2 power_down_flag_o && watchdog_timeout_clr_o)
      else $error("halt flags wrong");
   halt_wdt_a: assert property (halt_i && mode_o == SCM_RUN |-> ##2 watchdog_clr_o)
      else $error("watchdog not cleared");
   halt_hold_a: assert property (halt_i && mode_o == SCM_RUN |-> ##2 cpu_hold_o && mode_o != SCM_RUN)
      else $error("cpu not held");
   sleep_gates_a: assert property (mode_o == SCM_SLEEP |-> !sys_clk_en_o && !fast_clk_en_o && !slow_clk_en_o)
      else $error("clock runs in sleep");
   idle_zero_a: assert property (mode_o == SCM_IDLE_MODE_ZERO |-> !fast_clk_en_o && slow_clk_en_o)
      else $error("idle zero gates wrong");
   idle_one_a: assert property (mode_o == SCM_IDLE_MODE_ONE |-> fast_clk_en_o && slow_clk_en_o)
      else $error("idle one gates wrong");
   idle_two_a: assert property (mode_o == SCM_IDLE_MODE_TWO |-> fast_clk_en_o && !slow_clk_en_o)
      else $error("idle two gates wrong");
   switch_gap_a: assert property ($changed(sys_clk_sel_o) |-> !sys_clk_en_o)
      else $error("select changed with clock gated on");
   freq_apply_a: assert property ($changed(fast_osc_freq_o) |-> $past(fast_osc_rdy_i, 4))
      else $error("frequency applied before stable");
endmodule

bind scm_ctrl scm_ctrl_sva u_scm_ctrl_sva (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .halt_i(halt_i),
   .fast_osc_rdy_i(fast_osc_rdy_i), .fast_osc_freq_o(fast_osc_freq_o),
   .sys_clk_sel_o(sys_clk_sel_o), .sys_clk_en_o(sys_clk_en_o), .fast_clk_en_o(fast_clk_en_o),
   .slow_clk_en_o(slow_clk_en_o), .cpu_hold_o(cpu_hold_o),
   .power_down_flag_o(power_down_flag_o), .watchdog_timeout_clr_o(watchdog_timeout_clr_o),
   .watchdog_clr_o(watchdog_clr_o), .mode_o(mode_o)
);

// ===== test/scm_ctrl_tb.sv
// self-checking bench for the clock and power-mode control block
// assumes a classic wishbone slave; waits for ack or err with no fixed latency
`timescale 1ns/1ns
`include "scm_regs.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module scm_ctrl_tb;
   import scm_pkg::*;
   logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic        halt_i = 1'h0, wake_i = 1'h0, fast_osc_rdy_i = 1'h1, slow_osc_rdy_i = 1'h1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
   logic        wb_ack_o, wb_err_o, fast_osc_en_o, slow_osc_en_o, sys_clk_en_o, er;
   logic        fast_clk_en_o, slow_clk_en_o, cpu_hold_o, power_down_flag_o;
   logic [1:0]  fast_osc_freq_o;
   logic [2:0]  sys_clk_sel_o, mode_o;
   int          error_cnt = 0, samples_checked = 0;
   scm_mode_t   exp_mode [4] = '{SCM_SLEEP, SCM_IDLE_MODE_ZERO, SCM_IDLE_MODE_TWO, SCM_IDLE_MODE_ONE};

   always #5 clk_i = ~clk_i;

   scm_ctrl u_scm_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .halt_i(halt_i),
      .wake_i(wake_i), .fast_osc_rdy_i(fast_osc_rdy_i), .slow_osc_rdy_i(slow_osc_rdy_i),
      .fast_osc_en_o(fast_osc_en_o), .fast_osc_freq_o(fast_osc_freq_o),
      .slow_osc_en_o(slow_osc_en_o), .sys_clk_sel_o(sys_clk_sel_o),
      .sys_clk_en_o(sys_clk_en_o), .fast_clk_en_o(fast_clk_en_o),
      .slow_clk_en_o(slow_clk_en_o), .cpu_hold_o(cpu_hold_o),
      .power_down_flag_o(power_down_flag_o), .watchdog_timeout_clr_o(),
      .watchdog_clr_o(), .mode_o(mode_o)
   );

   task automatic end_sim;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one classic cycle; entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
      rd = wb_dat_o;
      er = wb_err_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i  <= 1'h0;
      @(posedge clk_i);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   // bounded wait: the switch must finish well inside 30 cycles
   task automatic wait_sel(input logic [2:0] s);
      int n;
      n = 0;
      while (sys_clk_sel_o !== s && n < 30) begin
         @(posedge clk_i);
         n++;
      end
      `CHK(sys_clk_sel_o, s)
   endtask

   initial begin
      tick(5);
      rst_i <= 1'h0;
      tick(1);
      xfer(`SCM_SYSCLK_OFS, 1'h0, 8'h00);
      `CHK(rd, 32'h0000_0000)
      xfer(`SCM_FASTOSC_OFS, 1'h0, 8'h00);
      `CHK(rd & 32'hFFFF_FFFD, 32'h0000_0001)
      xfer(`SCM_SYSCLK_OFS, 1'h1, 8'h13);
      xfer(`SCM_SYSCLK_OFS, 1'h0, 8'h00);
      `CHK(rd, 32'h0000_0003)
      xfer(`SCM_FASTOSC_OFS, 1'h1, 8'hF1);
      xfer(`SCM_FASTOSC_OFS, 1'h0, 8'h00);
      `CHK(rd & 32'hFFFF_FFFD, 32'h0000_0001)
      for (int c = 0; c < 8; c++) begin
         xfer(`SCM_SYSCLK_OFS, 1'h1, {c[2:0], 5'h00});
         wait_sel(c[2:0]);
      end
      xfer(`SCM_FASTOSC_OFS, 1'h1, 8'h00);
      tick(3);
      `CHK(fast_osc_en_o, 1'h0)
      fast_osc_rdy_i <= 1'h0;
      xfer(`SCM_FASTOSC_OFS, 1'h1, 8'h09);
      tick(4);
      xfer(`SCM_FASTOSC_OFS, 1'h0, 8'h00);
      `CHK(rd, 32'h0000_0009)
      `CHK(fast_osc_freq_o, 2'h0)
      fast_osc_rdy_i <= 1'h1;
      tick(6);
      xfer(`SCM_FASTOSC_OFS, 1'h0, 8'h00);
      `CHK(rd, 32'h0000_000B)
      `CHK(fast_osc_freq_o, 2'h2)
      for (int f = 0; f < 4; f++) begin
         xfer(`SCM_FASTOSC_OFS, 1'h1, {4'h0, f[1:0], 2'h1});
         tick(6);
         `CHK(fast_osc_freq_o, f[1:0])
      end
      // osc off and not ready: the return to a fast select must wait
      xfer(`SCM_FASTOSC_OFS, 1'h1, 8'h0C);
      fast_osc_rdy_i <= 1'h0;
      xfer(`SCM_SYSCLK_OFS, 1'h1, 8'h60);
      tick(20);
      `CHK(sys_clk_sel_o, 3'h7)
      fast_osc_rdy_i <= 1'h1;
      wait_sel(3'h3);
      for (int m = 0; m < 4; m++) begin
         xfer(`SCM_SYSCLK_OFS, 1'h1, 8'h60 | m[7:0]);
         halt_i <= 1'h1;
         tick(1);
         halt_i <= 1'h0;
         tick(3);
         `CHK(mode_o, exp_mode[m])
         `CHK(fast_clk_en_o, m[1])
         `CHK(slow_clk_en_o, m[0])
         `CHK(power_down_flag_o, 1'h1)
         `CHK(slow_osc_en_o, m[0])
         `CHK(sys_clk_en_o, m[1])
         `CHK(cpu_hold_o, 1'h1)
         xfer(`SCM_SYSCLK_OFS, 1'h0, 8'h00);
         `CHK(rd, 32'h0000_0060 | m)
         wake_i <= 1'h1;
         tick(1);
         wake_i <= 1'h0;
         tick(3);
         `CHK(mode_o, SCM_RUN)
         `CHK(cpu_hold_o, 1'h0)
         xfer(`SCM_STATUS_OFS, 1'h1, 8'h01);
         tick(1);
         `CHK(power_down_flag_o, 1'h0)
      end
      xfer(`SCM_HALT_OFS, 1'h0, 8'h00);
      `CHK(rd, 32'h0000_0000)
      xfer(8'h10, 1'h0, 8'h00);
      `CHK(er, 1'h1)
      end_sim;
   end

   initial begin
      tick(5000);
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      end_sim;
   end
endmodule
